// >>> rtl/ctw_pkg.sv
// Purpose: Constants for the clock, timebase and watchdog block
// Assumes: APB register map, 32-bit data, word-aligned offsets
// Notes: Offsets below are byte addresses
package ctw_pkg;
	// ***************************************
	// Register offsets
	// ***************************************
	localparam logic [7:0] SCR_OFF = 8'h00;
	localparam logic [7:0] MODE0_OFF = 8'h04;
	localparam logic [7:0] OPS_OFF = 8'h08;
	localparam logic [7:0] PRESCALE_OFF = 8'h0c;
	localparam logic [7:0] T0LO_OFF = 8'h10;
	localparam logic [7:0] T0HI_OFF = 8'h14;
	localparam logic [7:0] T0IMM_OFF = 8'h18;
	localparam logic [7:0] EVF_OFF = 8'h1c;
	localparam logic [7:0] IEN_OFF = 8'h20;
	localparam logic [7:0] PEN_OFF = 8'h24;
	localparam logic [7:0] HEN_OFF = 8'h28;
	localparam logic [7:0] STAT_OFF = 8'h2c;
	localparam logic [7:0] LCD_OFF = 8'h30;
	// ***************************************
	// Field positions
	// ***************************************
	localparam int SCR_SEL_BIT = 0;
	localparam int SCR_STOP_BIT = 1;
	localparam int SCR_HALF_BIT = 3;
	localparam int MODE0_CLK_BIT = 0;
	localparam int MODE0_RUN_BIT = 3;
	localparam int OP_DIV0_BIT = 0;
	localparam int OP_WDT_BIT = 1;
	localparam int PRESCALE_BIT = 3;
	localparam int LCD_DIV_BIT = 0;
	localparam int EV_DIV0 = 0;
	localparam int EV_T0 = 1;
	localparam int EV_DIV1 = 4;
	localparam int DIV0_CLR_LSB = 10;
	localparam int DIV1_HALF_MSB = 12;
	// ***************************************
	// Reset values and widths
	// ***************************************
	localparam logic [3:0] SCR_RESET = 4'h0;
	localparam logic [7:0] EVENT_MASK = 8'h13;
	localparam int DIV_W = 14;
	localparam int T0_FAST_DIV = 4;
	localparam int T0_SLOW_DIV = 1024;
	localparam int WDT_FAST_DIV = 1024;
	localparam int WDT_SLOW_DIV = 16384;
	localparam int LCD_DIV = 32;
	// ***************************************
	// Machine cycle phases
	// ***************************************
	typedef enum logic [1:0] {
		CTW_PH0 = 2'b00,
		CTW_PH1 = 2'b01,
		CTW_PH2 = 2'b11,
		CTW_PH3 = 2'b10
	} ctw_phase_type;
endpackage

// >>> rtl/ctw_timebase.sv
// Purpose: Clock select, dividers, watchdog and timer 0 of a 4-bit core
// Assumes: Oscillator clocks arrive as pins, sampled on pclk
// Notes: Core operations arrive as APB writes
// Function
// R01: Dual mode: select bit picks main or sub
// R02: Dual mode: stop bit halts main oscillator
// R03: Single mode ignores control, main always used
// R04: Software selects sub before stopping main
// R05: Software restarts main, waits, then selects
// R06: Software never writes stopped-yet-selected state
// R07: Display clock: sub, or main or main/32
// R08: Machine cycle is four system clock states
// R09: Divider 0 counts system clock, flags bit 0; here it does not count while the main oscillator is stopped
// R10: Events drive interrupt and hold-release requests
// R11: Divider 0 clear resets upper four stages
// R12: Divider 1 counts sub clock, flags bit 4
// R13: Divider 1 period 500 or 250 ms
// R14: Watchdog 4-bit, option gated, resets chip
// R15: Watchdog prescale 1024, or 16384 when flagged
// R16: Watchdog clear zeroes counter; software keeps clearing
// R17: Nibble load stops timer 0, then loads
// R18: Start clears flag 1, begins counting down
// R19: Underflow to FFH stops timer, sets flag 1
// R20: Timer 0 clock divide by 4 or 1024
// R21: Interval is preset plus one input periods
// R22: Interrupt needs flag, enable and master enable
// R23: Mode register write-only, bit 3 runs timer
// R24: Clock control resets to all zeros
// R25: Event flags stay set until cleared
//
// Design decisions made here: the register offsets and register access over APB.
`timescale 1ns/1ns
module ctw_timebase
	import ctw_pkg::*;
#(
	parameter int WDT_SLOW = WDT_SLOW_DIV
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Oscillator pins and option straps
	input wire logic main_osc_clock,
	input wire logic sub_osc_clock,
	input wire logic dual_clock_mode,
	input wire logic watchdog_option,
	// Clock control outputs
	output logic main_osc_enable,
	output logic sys_clock_tick,
	output logic machine_cycle_tick,
	output logic lcd_clock_tick,
	// Event outputs
	output logic irq_request,
	output logic hold_release,
	output logic chip_reset
);
	// ***************************************
	// Pin synchronisers
	// ***************************************
	logic [1:0] osc_s1, osc_s2, osc_s3;
	logic [1:0] strap_s1, strap_s2;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			osc_s1 <= 2'h0;
			osc_s2 <= 2'h0;
			osc_s3 <= 2'h0;
			strap_s1 <= 2'h0;
			strap_s2 <= 2'h0;
		end else begin
			osc_s1 <= {sub_osc_clock, main_osc_clock};
			osc_s2 <= osc_s1;
			osc_s3 <= osc_s2;
			strap_s1 <= {watchdog_option, dual_clock_mode};
			strap_s2 <= strap_s1;
		end
	end
	logic main_rise, sub_rise, dual, wdt_on;
	assign main_rise = osc_s2[0] & ~osc_s3[0];
	assign sub_rise = osc_s2[1] & ~osc_s3[1];
	assign dual = strap_s2[0];
	assign wdt_on = strap_s2[1];
	// ***************************************
	// APB decode
	// ***************************************
	function automatic logic ctw_mapped(input logic [7:0] a);
		if (a == SCR_OFF || a == MODE0_OFF || a == OPS_OFF || a == PRESCALE_OFF) begin
			return 1'b1;
		end else if (a == T0LO_OFF || a == T0HI_OFF || a == T0IMM_OFF || a == EVF_OFF) begin
			return 1'b1;
		end else if (a == IEN_OFF || a == PEN_OFF || a == HEN_OFF || a == STAT_OFF) begin
			return 1'b1;
		end else if (a == LCD_OFF) begin
			return 1'b1;
		end else begin
			return 1'b0;
		end
	endfunction
	logic wr;
	assign wr = psel & penable & pwrite & ctw_mapped(paddr);
	assign pready = 1'b1;
	assign pslverr = psel & penable & ~ctw_mapped(paddr);
	logic wr_scr, wr_mode0, wr_ops, wr_pre, wr_lo, wr_hi, wr_imm, wr_evf;
	assign wr_scr = wr && paddr == SCR_OFF;
	assign wr_mode0 = wr && paddr == MODE0_OFF;
	assign wr_ops = wr && paddr == OPS_OFF;
	assign wr_pre = wr && paddr == PRESCALE_OFF;
	assign wr_lo = wr && paddr == T0LO_OFF;
	assign wr_hi = wr && paddr == T0HI_OFF;
	assign wr_imm = wr && paddr == T0IMM_OFF;
	assign wr_evf = wr && paddr == EVF_OFF;
	// ***************************************
	// Control registers
	// ***************************************
	logic [3:0] scr_reg;
	logic [7:0] ien_reg, hen_reg;
	logic pen_reg, prescale_reg, lcd_div_reg, t0_sel_reg;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scr_reg <= SCR_RESET; // see R24
			ien_reg <= 8'h00;
			hen_reg <= 8'h00;
			pen_reg <= 1'b0;
			prescale_reg <= 1'b0;
			lcd_div_reg <= 1'b0;
			t0_sel_reg <= 1'b0;
		end else begin
			if (wr_scr) begin
				scr_reg <= pwdata[3:0];
			end
			if (wr && paddr == IEN_OFF) begin
				ien_reg <= pwdata[7:0] & EVENT_MASK;
			end
			if (wr && paddr == HEN_OFF) begin
				hen_reg <= pwdata[7:0] & EVENT_MASK;
			end
			if (wr && paddr == PEN_OFF) begin
				pen_reg <= pwdata[0];
			end
			if (wr_pre) begin
				prescale_reg <= pwdata[PRESCALE_BIT]; // see R15
			end
			if (wr && paddr == LCD_OFF) begin
				lcd_div_reg <= pwdata[LCD_DIV_BIT];
			end
			if (wr_mode0) begin
				t0_sel_reg <= pwdata[MODE0_CLK_BIT]; // see R20
			end
		end
	end
	// ***************************************
	// System clock selection
	// ***************************************
	logic main_run, use_sub, fosc_tick;
	assign main_run = !(dual && scr_reg[SCR_STOP_BIT]); // see R02 see R03
	assign use_sub = dual && scr_reg[SCR_SEL_BIT]; // see R01 see R03
	assign fosc_tick = use_sub ? sub_rise : (main_rise & main_run);
	assign main_osc_enable = main_run;
	assign sys_clock_tick = fosc_tick;
	// ***************************************
	// Display clock source
	// ***************************************
	logic [4:0] lcd_pre;
	logic lcd_next;
	assign lcd_next = dual ? sub_rise : (lcd_div_reg ? (main_rise && lcd_pre == 5'(LCD_DIV - 1)) : main_rise);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lcd_pre <= 5'h00;
			lcd_clock_tick <= 1'b0;
		end else begin
			if (main_rise) begin
				lcd_pre <= lcd_pre + 5'h01;
			end
			lcd_clock_tick <= lcd_next; // see R07
		end
	end
	// ***************************************
	// Machine cycle phases
	// ***************************************
	ctw_phase_type phase_reg, phase_next;
	always_comb begin
		case (phase_reg)
			CTW_PH0: phase_next = CTW_PH1;
			CTW_PH1: phase_next = CTW_PH2;
			CTW_PH2: phase_next = CTW_PH3;
			default: phase_next = CTW_PH0;
		endcase
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase_reg <= CTW_PH0;
			machine_cycle_tick <= 1'b0;
		end else begin
			if (fosc_tick) begin
				phase_reg <= phase_next; // see R08
			end
			machine_cycle_tick <= fosc_tick && phase_reg == CTW_PH3;
		end
	end
	// ***************************************
	// Dividers
	// ***************************************
	logic [DIV_W-1:0] div0_reg, div0_inc, div1_reg;
	logic div0_ovf, div1_ovf;
	assign div0_inc = (fosc_tick && main_run) ? div0_reg + 1'b1 : div0_reg;
	assign div0_ovf = fosc_tick && main_run && (&div0_reg); // see R09
	assign div1_ovf = sub_rise && dual && (scr_reg[SCR_HALF_BIT] ? (&div1_reg[DIV1_HALF_MSB:0]) : (&div1_reg)); // see R13
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div0_reg <= '0;
		end else if (wr_ops && pwdata[OP_DIV0_BIT]) begin
			div0_reg <= {{(DIV_W - DIV0_CLR_LSB){1'b0}}, div0_inc[DIV0_CLR_LSB-1:0]}; // see R11
		end else begin
			div0_reg <= div0_inc;
		end
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div1_reg <= '0;
		end else if (sub_rise && dual) begin
			div1_reg <= div1_reg + 1'b1; // see R12
		end
	end
	// ***************************************
	// Watchdog
	// ***************************************
	logic [13:0] wdt_pre;
	logic [3:0] wdt_cnt;
	logic wdt_tick;
	assign wdt_tick = wdt_on && fosc_tick && wdt_pre == (prescale_reg ? 14'(WDT_SLOW - 1) : 14'(WDT_FAST_DIV - 1));
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wdt_pre <= 14'h0000;
			wdt_cnt <= 4'h0;
			chip_reset <= 1'b0;
		end else begin
			chip_reset <= wdt_tick && (&wdt_cnt); // see R14
			if (!wdt_on || (wr_ops && pwdata[OP_WDT_BIT])) begin
				wdt_pre <= 14'h0000;
				wdt_cnt <= 4'h0; // see R16
			end else if (wdt_tick) begin
				wdt_pre <= 14'h0000; // see R15
				wdt_cnt <= wdt_cnt + 4'h1;
			end else if (fosc_tick) begin
				wdt_pre <= wdt_pre + 14'h0001;
			end
		end
	end
	// ***************************************
	// Timer 0
	// ***************************************
	logic [7:0] t0_cnt;
	logic [9:0] t0_pre;
	logic t0_run, t0_tick, t0_unf, t0_start;
	assign t0_start = (wr_mode0 && pwdata[MODE0_RUN_BIT]) || wr_imm; // see R23
	assign t0_tick = t0_run && fosc_tick && t0_pre == (t0_sel_reg ? 10'(T0_SLOW_DIV - 1) : 10'(T0_FAST_DIV - 1));
	assign t0_unf = t0_tick && t0_cnt == 8'h00 && !(wr_lo || wr_hi || wr_imm || wr_mode0);
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			t0_cnt <= 8'h00;
			t0_pre <= 10'h000;
			t0_run <= 1'b0;
		end else if (wr_lo) begin
			t0_cnt[3:0] <= pwdata[3:0]; // see R17
			t0_run <= 1'b0;
		end else if (wr_hi) begin
			t0_cnt[7:4] <= pwdata[3:0]; // see R17
			t0_run <= 1'b0;
		end else if (wr_imm) begin
			t0_cnt <= pwdata[7:0];
			t0_pre <= 10'h000;
			t0_run <= 1'b1;
		end else if (wr_mode0) begin
			t0_pre <= 10'h000; // see R21
			t0_run <= pwdata[MODE0_RUN_BIT]; // see R18 see R23
		end else if (t0_tick) begin
			t0_pre <= 10'h000;
			t0_cnt <= t0_cnt - 8'h01; // see R20 see R21
			if (t0_cnt == 8'h00) begin
				t0_run <= 1'b0; // see R19
			end
		end else if (t0_run && fosc_tick) begin
			t0_pre <= t0_pre + 10'h001;
		end
	end
	// ***************************************
	// Event flags and requests
	// ***************************************
	logic [7:0] evf_reg, evf_set, evf_clr;
	always_comb begin
		evf_set = 8'h00;
		evf_set[EV_DIV0] = div0_ovf;
		evf_set[EV_T0] = t0_unf; // see R19
		evf_set[EV_DIV1] = div1_ovf; // see R12
		evf_clr = wr_evf ? pwdata[7:0] : 8'h00;
		evf_clr[EV_T0] = evf_clr[EV_T0] | t0_start; // see R18
	end
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			evf_reg <= 8'h00;
		end else begin
			evf_reg <= ((evf_reg & ~evf_clr) | evf_set) & EVENT_MASK; // see R25
		end
	end
	assign irq_request = pen_reg && |(evf_reg & ien_reg); // see R10 see R22
	assign hold_release = |(evf_reg & hen_reg); // see R10
	// ***************************************
	// Read data
	// ***************************************
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0;
		end else if (psel && !penable && !pwrite) begin
			if (paddr == SCR_OFF) begin
				prdata <= {28'h0, scr_reg};
			end else if (paddr == PRESCALE_OFF) begin
				prdata <= {28'h0, prescale_reg, 3'h0};
			end else if (paddr == EVF_OFF) begin
				prdata <= {24'h0, evf_reg};
			end else if (paddr == IEN_OFF) begin
				prdata <= {24'h0, ien_reg};
			end else if (paddr == PEN_OFF) begin
				prdata <= {31'h0, pen_reg};
			end else if (paddr == HEN_OFF) begin
				prdata <= {24'h0, hen_reg};
			end else if (paddr == STAT_OFF) begin
				prdata <= {2'h0, div0_reg, dual, use_sub, main_run, t0_run, wdt_cnt, t0_cnt};
			end else if (paddr == LCD_OFF) begin
				prdata <= {31'h0, lcd_div_reg};
			end else begin
				prdata <= 32'h0;
			end
		end
	end
	// ***************************************
	// Assertions
	// ***************************************
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_r01;
		dual && scr_reg[SCR_SEL_BIT] |-> fosc_tick == sub_rise;
	endproperty
	a_r01: assert property (p_r01) else $error("sub clock not used"); // see R01
	property p_r02;
		dual && scr_reg[SCR_STOP_BIT] |-> !main_osc_enable;
	endproperty
	a_r02: assert property (p_r02) else $error("main oscillator not stopped"); // see R02
	property p_r03;
		!dual |-> main_osc_enable && fosc_tick == main_rise;
	endproperty
	a_r03: assert property (p_r03) else $error("single mode clock wrong"); // see R03
	property p_r07;
		dual && $past(dual) |-> lcd_clock_tick == $past(sub_rise);
	endproperty
	a_r07: assert property (p_r07) else $error("display clock not sub clock"); // see R07
	property p_r08;
		machine_cycle_tick |-> $past(fosc_tick) && phase_reg == CTW_PH0;
	endproperty
	a_r08: assert property (p_r08) else $error("machine cycle phase wrong"); // see R08
	property p_r09;
		div0_ovf |=> evf_reg[EV_DIV0] && div0_reg[DIV0_CLR_LSB-1:0] == '0;
	endproperty
	a_r09: assert property (p_r09) else $error("divider 0 overflow lost"); // see R09
	property p_r11;
		wr_ops && pwdata[OP_DIV0_BIT] |=> div0_reg[DIV_W-1:DIV0_CLR_LSB] == '0;
	endproperty
	a_r11: assert property (p_r11) else $error("divider 0 upper not cleared"); // see R11
	property p_r14;
		!wdt_on |=> wdt_cnt == 4'h0 && !chip_reset;
	endproperty
	a_r14: assert property (p_r14) else $error("watchdog active while off"); // see R14
	property p_r16;
		wr_ops && pwdata[OP_WDT_BIT] |=> wdt_cnt == 4'h0 ##1 !chip_reset;
	endproperty
	a_r16: assert property (p_r16) else $error("watchdog not cleared"); // see R16
	property p_r17;
		wr_lo || wr_hi |=> !t0_run && ($past(wr_lo) ? t0_cnt[3:0] : t0_cnt[7:4]) == $past(pwdata[3:0]);
	endproperty
	a_r17: assert property (p_r17) else $error("nibble load failed"); // see R17
	property p_r18;
		t0_start && !t0_unf |=> t0_run && !evf_reg[EV_T0];
	endproperty
	a_r18: assert property (p_r18) else $error("timer 0 start failed"); // see R18
	property p_r19;
		t0_unf |=> !t0_run && t0_cnt == 8'hff && evf_reg[EV_T0];
	endproperty
	a_r19: assert property (p_r19) else $error("timer 0 underflow wrong"); // see R19
	property p_r22;
		irq_request |-> pen_reg && |(evf_reg & ien_reg);
	endproperty
	a_r22: assert property (p_r22) else $error("interrupt without cause"); // see R22
	c_t0_underflow: cover property (t0_unf);
	c_wdt_reset: cover property (chip_reset);
	c_div1_event: cover property (div1_ovf ##1 hold_release);
	c_slow_mode: cover property (use_sub && !main_osc_enable);
endmodule

// >>> verification/ctw_osc_model.sv
// Purpose: Oscillator pins seen by the timebase block
// Assumes: Half periods of at least two pclk cycles
// Notes: Main output parks low while its enable is low
`timescale 1ns/1ns
module ctw_osc_model #(
	parameter int MAIN_HALF_NS = 20,
	parameter int SUB_HALF_NS = 30
) (
	// Control from the block
	input wire logic main_osc_enable,
	// Oscillator pins
	output logic main_osc_clock,
	output logic sub_osc_clock
);
	// ***************************************
	// Oscillators
	// ***************************************
	initial begin
		main_osc_clock = 1'b0;
		#3;
		forever begin
			#MAIN_HALF_NS;
			main_osc_clock = main_osc_enable ? ~main_osc_clock : 1'b0;
		end
	end
	initial begin
		sub_osc_clock = 1'b0;
		#7;
		forever begin
			#SUB_HALF_NS;
			sub_osc_clock = ~sub_osc_clock;
		end
	end
endmodule

// >>> verification/ctw_timebase_tb.sv
// Purpose: Self-checking bench of the clock, timebase and watchdog block
// Assumes: Zero wait state APB, shortened watchdog slow prescale
// Notes: Main osc 4 pclk per period, sub osc 6 pclk per period
`timescale 1ns/1ns
module ctw_timebase_tb;
	import ctw_pkg::*;
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin miscompares++; \
$display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end
	// ***************************************
	// Signals
	// ***************************************
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic main_osc_clock;
	logic sub_osc_clock;
	logic dual_clock_mode = 1'b1;
	logic watchdog_option = 1'b0;
	logic main_osc_enable;
	logic sys_clock_tick;
	logic machine_cycle_tick;
	logic lcd_clock_tick;
	logic irq_request;
	logic hold_release;
	logic chip_reset;
	logic [31:0] rd;
	logic err;
	logic [13:0] s1;
	int miscompares = 0;
	int n_tests = 0;
	int cyc = 0;
	int n_lcd = 0;
	int n_wdt = 0;
	int t;
	int a;
	always #5 pclk = ~pclk;
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		n_lcd <= n_lcd + ((lcd_clock_tick === 1'b1) ? 1 : 0);
		n_wdt <= n_wdt + ((chip_reset === 1'b1) ? 1 : 0);
	end
	ctw_timebase #(.WDT_SLOW(32)) ctw_timebase_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.main_osc_clock(main_osc_clock), .sub_osc_clock(sub_osc_clock), .dual_clock_mode(dual_clock_mode),
		.watchdog_option(watchdog_option), .main_osc_enable(main_osc_enable), .sys_clock_tick(sys_clock_tick),
		.machine_cycle_tick(machine_cycle_tick), .lcd_clock_tick(lcd_clock_tick), .irq_request(irq_request),
		.hold_release(hold_release), .chip_reset(chip_reset));
	ctw_osc_model ctw_osc_model_i (.main_osc_enable(main_osc_enable), .main_osc_clock(main_osc_clock),
		.sub_osc_clock(sub_osc_clock));
	// ***************************************
	// Tasks
	// ***************************************
	task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= ad;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1) begin
			miscompares++;
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic settle;
		@(posedge pclk);
		#1;
	endtask
	task automatic ticks_until_irq(output int k);
		int n;
		k = 0;
		n = 0;
		while (irq_request !== 1'b1 && n < 20000) begin
			@(posedge pclk);
			k += (sys_clock_tick === 1'b1) ? 1 : 0;
			n++;
		end
	endtask
	task automatic report_and_stop;
		if (miscompares == 0 && n_tests > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	initial begin
		#800000;
		miscompares++;
		report_and_stop();
	end
	// ***************************************
	// Tests
	// ***************************************
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, SCR_OFF, 32'h0);
		`CHK("ctrl reset", 32'h0, rd)
		apb(1'b0, PRESCALE_OFF, 32'h0);
		`CHK("prescale reset", 1'b0, rd[3])
		apb(1'b0, 8'h3c, 32'h0);
		`CHK("unmapped err", 1'b1, err)
		apb(1'b1, SCR_OFF, 32'h8);
		apb(1'b1, HEN_OFF, 32'h10);
		while (hold_release !== 1'b1 && cyc < 60000) @(posedge pclk);
		`CHK("div1 period", 1'b1, cyc inside {[48900:49500]})
		apb(1'b1, EVF_OFF, 32'h13);
		settle();
		`CHK("div1 flag clear", 1'b0, hold_release)
		apb(1'b1, HEN_OFF, 32'h0);
		apb(1'b1, SCR_OFF, 32'h9);
		apb(1'b0, STAT_OFF, 32'h0);
		`CHK("sub selected", 1'b1, rd[14])
		apb(1'b1, SCR_OFF, 32'hb);
		settle();
		`CHK("main stopped", 1'b0, main_osc_enable)
		while (machine_cycle_tick !== 1'b1 && cyc < 60000) @(posedge pclk);
		t = 0;
		do begin
			@(posedge pclk);
			t += (sys_clock_tick === 1'b1) ? 1 : 0;
		end while (machine_cycle_tick !== 1'b1 && t < 10);
		`CHK("machine cycle", 4, t)
		a = n_lcd;
		repeat (600) @(posedge pclk);
		`CHK("lcd dual", 1'b1, (n_lcd - a) inside {[99:101]})
		apb(1'b1, SCR_OFF, 32'h9);
		repeat (200) @(posedge pclk);
		apb(1'b1, SCR_OFF, 32'h8);
		settle();
		`CHK("main restarted", 1'b1, main_osc_enable)
		@(posedge pclk);
		dual_clock_mode <= 1'b0;
		apb(1'b1, SCR_OFF, 32'hb);
		settle();
		`CHK("single main on", 1'b1, main_osc_enable)
		apb(1'b0, STAT_OFF, 32'h0);
		`CHK("single main sel", 1'b0, rd[14])
		for (int i = 0; i < 2; i++) begin
			apb(1'b1, LCD_OFF, i);
			a = n_lcd;
			repeat (1280) @(posedge pclk);
			`CHK("lcd single", 1'b1, (n_lcd - a) inside {[(i ? 9 : 319):(i ? 11 : 321)]})
		end
		apb(1'b0, STAT_OFF, 32'h0);
		s1 = rd[29:16];
		repeat (400) @(posedge pclk);
		apb(1'b0, STAT_OFF, 32'h0);
		`CHK("div0 rate", 1'b1, 14'(rd[29:16] - s1) inside {[99:102]})
		s1 = rd[29:16];
		apb(1'b1, OPS_OFF, 32'h1);
		apb(1'b0, STAT_OFF, 32'h0);
		`CHK("div0 upper clear", 4'h0, rd[29:26])
		`CHK("div0 lower kept", 1'b1, 10'(rd[25:16] - s1[9:0]) inside {[1:4]})
		apb(1'b1, EVF_OFF, 32'h13);
		apb(1'b1, IEN_OFF, 32'h2);
		apb(1'b1, PEN_OFF, 32'h1);
		apb(1'b1, T0IMM_OFF, 32'h2);
		ticks_until_irq(t);
		`CHK("t0 fast interval", 12, t)
		apb(1'b0, STAT_OFF, 32'h0);
		`CHK("t0 underflow", 9'h0ff, {rd[12], rd[7:0]})
		repeat (50) @(posedge pclk);
		`CHK("flag holds", 1'b1, irq_request)
		apb(1'b1, PEN_OFF, 32'h0);
		settle();
		`CHK("master gate", 1'b0, irq_request)
		apb(1'b1, HEN_OFF, 32'h2);
		settle();
		`CHK("hold release", 1'b1, hold_release)
		apb(1'b1, HEN_OFF, 32'h0);
		apb(1'b1, T0LO_OFF, 32'h5);
		apb(1'b1, T0HI_OFF, 32'ha);
		apb(1'b1, MODE0_OFF, 32'h8);
		apb(1'b0, EVF_OFF, 32'h0);
		`CHK("start clears flag", 1'b0, rd[1])
		repeat (20) @(posedge pclk);
		apb(1'b1, T0LO_OFF, 32'h0);
		apb(1'b1, T0HI_OFF, 32'h0);
		apb(1'b0, STAT_OFF, 32'h0);
		`CHK("load stops t0", 9'h000, {rd[12], rd[7:0]})
		apb(1'b0, MODE0_OFF, 32'h0);
		`CHK("mode write only", 32'h0, rd)
		apb(1'b1, PEN_OFF, 32'h1);
		apb(1'b1, MODE0_OFF, 32'h9);
		ticks_until_irq(t);
		`CHK("t0 slow interval", 1024, t)
		apb(1'b1, PRESCALE_OFF, 32'h8);
		apb(1'b0, PRESCALE_OFF, 32'h0);
		`CHK("prescale set", 1'b1, rd[3])
		watchdog_option <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			repeat (1000) @(posedge pclk);
			apb(1'b1, OPS_OFF, 32'h2);
		end
		`CHK("wdt kept clear", 0, n_wdt)
		a = cyc;
		while (n_wdt == 0 && cyc - a < 3000) @(posedge pclk);
		`CHK("wdt overflow", 1'b1, (cyc - a) inside {[1900:2120]})
		report_and_stop();
	end
endmodule
